// ---- inc/svp_pkg.sv ----
package svp_pkg;
    // clock and time base
    localparam int CLK_HZ        = 100_000_000;
    localparam int TICK_MS       = 5;
    localparam int TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
    localparam int AVG_MS        = 20;
    localparam int AVG_SAMPLES   = AVG_MS / TICK_MS;
    localparam int HIST_SAMPLES  = 2 * AVG_SAMPLES;
    // widths
    localparam int AW            = 8;
    localparam int DW            = 32;
    localparam int MW            = 16;
    localparam int RW            = 18;
    localparam int NUM_GROUPS    = 8;
    localparam int GW            = 3;
    // hysteresis and scaling, magnitudes in 0.01 %Un
    localparam int HYST_OVER_PCT  = 97;
    localparam int HYST_UNDER_PCT = 103;
    localparam int PCT_BASE       = 100;
    localparam int PCT_FULL       = 10000;
    // register byte offsets
    localparam logic [AW-1:0] OFS_CTRL     = 8'h00;
    localparam logic [AW-1:0] OFS_UNDER_BLOCK_LEVEL     = 8'h04;
    localparam logic [AW-1:0] OFS_OPDLY    = 8'h08;
    localparam logic [AW-1:0] OFS_UNPRIM   = 8'h0c;
    localparam logic [AW-1:0] OFS_STATUS   = 8'h10;
    localparam logic [AW-1:0] OFS_CALC     = 8'h14;
    localparam logic [AW-1:0] OFS_RATIO    = 8'h18;
    localparam logic [AW-1:0] OFS_PREFAULT = 8'h1c;
    localparam logic [AW-1:0] OFS_EXPTIME  = 8'h20;
    localparam logic [AW-1:0] OFS_REMTIME  = 8'h24;
    localparam logic [AW-1:0] OFS_PRIMARY  = 8'h28;
    localparam logic [AW-1:0] OFS_USET     = 8'h40;
    localparam logic [2:0]    USET_PAGE    = 3'h2;
    // control field positions
    localparam int CTRL_FORCE_LSB = 0;
    localparam int CTRL_MAG_LSB   = 2;
    localparam int CTRL_UNDER_BIT = 4;
    // reset values
    localparam logic [MW-1:0] RST_USET   = 16'h2904;
    localparam logic [MW-1:0] RST_UNDER_BLOCK_LEVEL   = 16'h01f4;
    localparam logic [MW-1:0] RST_OPDLY  = 16'h0008;
    localparam logic [23:0]   RST_UNPRIM = 24'h0003e8;
    // settings encodings
    typedef enum logic [1:0] {
        SVP_FRC_NORMAL  = 2'b00,
        SVP_FRC_START   = 2'b01,
        SVP_FRC_TRIP    = 2'b10,
        SVP_FRC_BLOCKED = 2'b11
    } svp_force_t;
    localparam logic [1:0] MAG_POS = 2'h1;
    localparam logic [1:0] MAG_NEG = 2'h2;
endpackage

// ---- design/svp_prefault_avg.sv ----
`timescale 1ns/1ps
`default_nettype none
module svp_prefault_avg #(
    parameter int HIST = 8,
    parameter int NAVG = 4,
    parameter int W    = 16
) (
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic         sample_valid,
    input  wire logic [W-1:0] sample,
    output logic      [W-1:0] avg
);
    typedef struct packed {
        logic [HIST-1:0][W-1:0] hist;
        logic [W-1:0]           avg;
    } svp_avg_state_t;

    svp_avg_state_t s_q;
    svp_avg_state_t s_d;

    ////////////////////////////////////////////////////////////////////////
    // the oldest samples form the window ending one window before now
    always_comb begin
        logic [W+7:0] sum;
        sum = '0;
        s_d = s_q;
        if (sample_valid) begin
            s_d.hist = {s_q.hist[HIST-2:0], sample};
            for (int i = HIST - NAVG; i < HIST; i++) begin
                sum = sum + (W+8)'(s_d.hist[i]);
            end
            s_d.avg = W'(sum / (W+8)'(NAVG));
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign avg = s_q.avg;
endmodule
`default_nettype wire

// ---- design/svp_scale.sv ----
`timescale 1ns/1ps
`default_nettype none
module svp_scale (
    input  wire logic                 clk,
    input  wire logic                 rstn,
    input  wire logic [svp_pkg::MW-1:0] calc,
    input  wire logic [svp_pkg::MW-1:0] uset,
    input  wire logic [23:0]          un_prim,
    output logic      [svp_pkg::RW-1:0] ratio,
    output logic      [31:0]          primary
);
    import svp_pkg::*;

    typedef struct packed {
        logic [RW-1:0] ratio;
        logic [31:0]   primary;
    } svp_scale_state_t;

    svp_scale_state_t s_q;
    svp_scale_state_t s_d;

    ////////////////////////////////////////////////////////////////////////
    // divider is combinational; one cycle latency is harmless at 5 ms updates
    always_comb begin
        logic [39:0] prod;
        logic [31:0] num;
        prod = 40'(uset) * 40'(un_prim);
        num  = 32'(calc) * 32'(PCT_BASE);
        s_d = s_q;
        s_d.ratio   = (uset == '0) ? '0 : RW'(num / 32'(uset));
        s_d.primary = 32'(prod / 40'(PCT_FULL));
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign ratio   = s_q.ratio;
    assign primary = s_q.primary;
endmodule
`default_nettype wire

// ---- design/svp_stage.sv ----
// How it works
// - magnitudes sampled once every 5 ms tick
// - pre-fault is 20 ms average, 20 ms earlier
// - force status overrides outputs under stage forcing
// - magnitude select: 1 positive, 2 negative
// - direction setting picks over or under pick-up
// - over mode releases below 97 % level
// - under mode releases above 103 % level
// - group pick-up level, 0.01 % steps, 105 %
// - under block level, default 5 %
// - under block holds until all lines recover
// - block level zero disables under blocking
// - start only when block input is low; under block holds off trip only
// - general settings not tied to groups
// - expected operating time in 5 ms units
// - signed remaining time while counting to trip
// - ratio of magnitude to pick-up, 0.01
// - pick-up level in primary 0.1 V
// - block sampled on each tick, sets blocked output while picked up
//
// Implementation choices: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
module svp_stage #(
    parameter int TICK_CYCLES = svp_pkg::TICK_CYCLES
) (
    input  wire logic                   clk,
    input  wire logic                   rstn,
    input  wire logic [svp_pkg::AW-1:0] addr,
    input  wire logic [svp_pkg::DW-1:0] wdata,
    input  wire logic                   wr,
    input  wire logic                   rd,
    output logic      [svp_pkg::DW-1:0] rdata,
    input  wire logic [svp_pkg::MW-1:0] pos_seq_rms,
    input  wire logic [svp_pkg::MW-1:0] neg_seq_rms,
    input  wire logic [svp_pkg::MW-1:0] line12_rms,
    input  wire logic [svp_pkg::MW-1:0] line23_rms,
    input  wire logic [svp_pkg::MW-1:0] line31_rms,
    input  wire logic                   block_in,
    input  wire logic                   stage_force_en,
    input  wire logic [svp_pkg::GW-1:0] group_sel,
    output logic                        start,
    output logic                        trip,
    output logic                        blocked
);
    import svp_pkg::*;

    typedef struct packed {
        logic [23:0]                   tick_cnt;
        svp_force_t                    force_st;
        logic [1:0]                    mag_sel;
        logic                          under;
        logic [MW-1:0]                 under_block_level;
        logic [MW-1:0]                 opdly;
        logic [23:0]                   un_prim;
        logic [NUM_GROUPS-1:0][MW-1:0] uset;
        logic [MW-1:0]                 calc_magnitude;
        logic                          pickup;
        logic                          uvblk;
        logic                          run_start;
        logic                          run_trip;
        logic                          run_blocked;
        logic [MW-1:0]                 elapsed;
        logic                          o_start;
        logic                          o_trip;
        logic                          o_blocked;
        logic                          ev_prev;
        logic [MW-1:0]                 prefault;
        logic [DW-1:0]                 rdata;
    } svp_state_t;

    svp_state_t s_q;
    svp_state_t s_d;

    logic                tick;
    logic [MW-1:0]       avg_out;
    logic [RW-1:0]       ratio;
    logic [31:0]         primary;
    logic [MW-1:0]       uset_cur;
    logic [MW-1:0]       sel_mag;
    logic signed [MW:0]  remaining;

    localparam logic [23:0] TICK_LAST = 24'(TICK_CYCLES - 1);

    ////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic is_uset(input logic [AW-1:0] a);
        return a[AW-1:5] == USET_PAGE;
    endfunction

    function automatic logic [19:0] pct_of(input logic [MW-1:0] v, input int pct);
        logic [31:0] p;
        p = 32'(v) * 32'(pct);
        return 20'(p / 32'(PCT_BASE));
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // time base and selected magnitude

    assign tick     = (s_q.tick_cnt == TICK_LAST);
    assign uset_cur = s_q.uset[group_sel];
    // unknown codes fall back to positive sequence
    assign sel_mag  = (s_q.mag_sel == MAG_NEG) ? neg_seq_rms : pos_seq_rms;
    assign remaining = $signed({1'b0, s_q.opdly}) - $signed({1'b0, s_q.elapsed});

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        logic        pick_n;
        logic        uv_n;
        logic        lines_ok;
        logic [19:0] thr;
        pick_n   = 1'b0;
        uv_n     = 1'b0;
        lines_ok = 1'b0;
        thr      = '0;
        s_d = s_q;
        s_d.tick_cnt = tick ? '0 : s_q.tick_cnt + 24'h000001;

        // register writes; settings are static apart from the group table
        if (wr) begin
            if (addr == OFS_CTRL) begin
                s_d.force_st = svp_force_t'(wdata[CTRL_FORCE_LSB +: 2]);
                s_d.mag_sel  = wdata[CTRL_MAG_LSB +: 2];
                s_d.under    = wdata[CTRL_UNDER_BIT];
            end
            if (addr == OFS_UNDER_BLOCK_LEVEL) begin
                s_d.under_block_level = wdata[MW-1:0];
            end
            if (addr == OFS_OPDLY) begin
                s_d.opdly = wdata[MW-1:0];
            end
            if (addr == OFS_UNPRIM) begin
                s_d.un_prim = wdata[23:0];
            end
            if (is_uset(addr)) begin
                s_d.uset[addr[4:2]] = wdata[MW-1:0];
            end
        end

        // comparison, hysteresis and blocking run only on the update tick
        if (tick) begin
            s_d.calc_magnitude = sel_mag;
            if (!s_q.under) begin
                if (s_q.pickup) begin
                    thr    = pct_of(uset_cur, HYST_OVER_PCT);
                    pick_n = !(20'(sel_mag) < thr);
                end else begin
                    pick_n = sel_mag > uset_cur;
                end
            end else begin
                if (s_q.pickup) begin
                    thr    = pct_of(uset_cur, HYST_UNDER_PCT);
                    pick_n = !(20'(sel_mag) > thr);
                end else begin
                    pick_n = sel_mag < uset_cur;
                end
            end
            s_d.pickup = pick_n;

            // de-energised network latch, only in under mode with nonzero level
            lines_ok = (line12_rms > uset_cur) && (line23_rms > uset_cur)
                       && (line31_rms > uset_cur);
            if (s_q.under && (s_q.under_block_level != '0)) begin
                if (sel_mag < s_q.under_block_level) begin
                    uv_n = 1'b1;
                end else if (s_q.uvblk && !lines_ok) begin
                    uv_n = 1'b1;
                end
            end
            s_d.uvblk = uv_n;

            // block input is looked at before start is allowed
            if (!pick_n) begin
                s_d.run_start   = 1'b0;
                s_d.run_trip    = 1'b0;
                s_d.run_blocked = 1'b0;
                s_d.elapsed     = '0;
            end else if (block_in) begin
                s_d.run_blocked = 1'b1;
                s_d.run_start   = 1'b0;
                s_d.run_trip    = 1'b0;
                s_d.elapsed     = '0;
            end else begin
                s_d.run_blocked = 1'b0;
                s_d.run_start   = 1'b1;
                // trip is held off but the timer keeps its count
                if (uv_n) begin
                    s_d.run_trip = 1'b0;
                end else if (s_q.elapsed >= s_q.opdly) begin
                    s_d.run_trip = 1'b1;
                end else begin
                    s_d.elapsed = s_q.elapsed + 16'h0001;
                end
            end
        end

        // forcing replaces the outputs, never the internal evaluation
        if (stage_force_en && (s_q.force_st != SVP_FRC_NORMAL)) begin
            s_d.o_start   = (s_q.force_st == SVP_FRC_START)
                            || (s_q.force_st == SVP_FRC_TRIP);
            s_d.o_trip    = (s_q.force_st == SVP_FRC_TRIP);
            s_d.o_blocked = (s_q.force_st == SVP_FRC_BLOCKED);
        end else begin
            s_d.o_start   = s_d.run_start;
            s_d.o_trip    = s_d.run_trip;
            s_d.o_blocked = s_d.run_blocked;
        end

        // pre-fault capture one cycle after start or trip rises: a rise on a
        // tick then sees the average that already holds that tick's sample
        s_d.ev_prev = s_q.o_start || s_q.o_trip;
        if (s_d.ev_prev && !s_q.ev_prev) begin
            s_d.prefault = avg_out;
        end

        // read data stands the cycle after the strobe only
        s_d.rdata = '0;
        if (rd) begin
            if (addr == OFS_CTRL) begin
                s_d.rdata = DW'({s_q.under, s_q.mag_sel, s_q.force_st});
            end else if (addr == OFS_UNDER_BLOCK_LEVEL) begin
                s_d.rdata = DW'(s_q.under_block_level);
            end else if (addr == OFS_OPDLY) begin
                s_d.rdata = DW'(s_q.opdly);
            end else if (addr == OFS_UNPRIM) begin
                s_d.rdata = DW'(s_q.un_prim);
            end else if (addr == OFS_STATUS) begin
                s_d.rdata = DW'({s_q.uvblk, s_q.o_blocked, s_q.o_trip,
                                 s_q.o_start, s_q.pickup});
            end else if (addr == OFS_CALC) begin
                s_d.rdata = DW'(s_q.calc_magnitude);
            end else if (addr == OFS_RATIO) begin
                s_d.rdata = DW'(ratio);
            end else if (addr == OFS_PREFAULT) begin
                s_d.rdata = DW'(s_q.prefault);
            end else if (addr == OFS_EXPTIME) begin
                s_d.rdata = DW'(s_q.opdly);
            end else if (addr == OFS_REMTIME) begin
                // zero when not counting; negative only once overdue
                s_d.rdata = s_q.run_start ? DW'(remaining) : '0;
            end else if (addr == OFS_PRIMARY) begin
                s_d.rdata = primary;
            end else if (is_uset(addr)) begin
                s_d.rdata = DW'(s_q.uset[addr[4:2]]);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_q         <= '0;
            s_q.mag_sel <= MAG_POS;
            s_q.under_block_level    <= RST_UNDER_BLOCK_LEVEL;
            s_q.opdly   <= RST_OPDLY;
            s_q.un_prim <= RST_UNPRIM;
            s_q.uset    <= {NUM_GROUPS{RST_USET}};
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // helpers: history average and scaling

    svp_prefault_avg #(
        .HIST (HIST_SAMPLES),
        .NAVG (AVG_SAMPLES),
        .W    (MW)
    ) u_avg (
        .clk          (clk),
        .rstn         (rstn),
        .sample_valid (tick),
        .sample       (sel_mag),
        .avg          (avg_out)
    );

    svp_scale u_scale (
        .clk     (clk),
        .rstn    (rstn),
        .calc    (s_q.calc_magnitude),
        .uset    (uset_cur),
        .un_prim (s_q.un_prim),
        .ratio   (ratio),
        .primary (primary)
    );

    assign rdata   = s_q.rdata;
    assign start   = s_q.o_start;
    assign trip    = s_q.o_trip;
    assign blocked = s_q.o_blocked;
endmodule
`default_nettype wire

// ---- tb/svp_stage_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module svp_stage_sva #(
    parameter int TICK_CYCLES = 20
) (
    input wire logic                   clk,
    input wire logic                   rstn,
    input wire logic [svp_pkg::AW-1:0] addr,
    input wire logic [svp_pkg::DW-1:0] wdata,
    input wire logic                   wr,
    input wire logic                   block_in,
    input wire logic                   stage_force_en,
    input wire logic                   start,
    input wire logic                   trip,
    input wire logic                   blocked
);
    import svp_pkg::*;
    int          cnt_q;
    logic [1:0]  frc_q;
    logic        fe1_q;
    logic        fe2_q;
    logic        nf;
    // shadow of the tick phase, the force field and the forcing history
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= 0;
            frc_q <= 2'h0;
            fe1_q <= 1'b0;
            fe2_q <= 1'b0;
        end else begin
            cnt_q <= (cnt_q == TICK_CYCLES - 1) ? 0 : cnt_q + 1;
            if (wr && addr == OFS_CTRL) begin
                frc_q <= wdata[CTRL_FORCE_LSB +: 2];
            end
            fe1_q <= stage_force_en;
            fe2_q <= fe1_q;
        end
    end
    // forcing takes a cycle to let go, so trust the tick only after three clear samples
    assign nf = !stage_force_en && !fe1_q && !fe2_q;
    ////////////////////////////////////////
    default clocking dcb @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence s_forced;
        stage_force_en && fe1_q && frc_q != 2'h0 && $stable(frc_q);
    endsequence
    sequence s_blk_tick;
        nf && cnt_q == 0 && $past(block_in);
    endsequence
    a_force_map: assert property (
        s_forced |-> {start, trip, blocked} == {frc_q != 2'h3, frc_q == 2'h2, frc_q == 2'h3})
        else $error("forced outputs wrong");
    a_quiet_between: assert property (
        nf && cnt_q != 0 |-> $stable({start, trip, blocked}))
        else $error("outputs moved between ticks");
    a_start_cause: assert property (
        nf && $rose(start) |-> !$past(block_in))
        else $error("start rose while blocked");
    a_blocked_cause: assert property (
        nf && $rose(blocked) |-> $past(block_in))
        else $error("blocked rose without block input");
    a_block_clears: assert property (
        s_blk_tick |-> !start && !trip)
        else $error("start or trip under block");
    a_trip_start: assert property (
        trip |-> start)
        else $error("trip without start");
    a_start_excl: assert property (
        !(start && blocked))
        else $error("start and blocked together");
    a_reset_clear: assert property (
        $rose(rstn) |-> !start && !trip && !blocked)
        else $error("outputs not clear after reset");
endmodule
`default_nettype wire

// ---- tb/svp_meas_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module svp_meas_model #(
    parameter int TICK_CYCLES = 20
) (
    input  wire logic                   clk,
    input  wire logic                   rstn,
    input  wire logic [svp_pkg::MW-1:0] t_pos,
    input  wire logic [svp_pkg::MW-1:0] t_neg,
    input  wire logic [svp_pkg::MW-1:0] t_line,
    output logic      [svp_pkg::MW-1:0] pos_seq_rms,
    output logic      [svp_pkg::MW-1:0] neg_seq_rms,
    output logic      [svp_pkg::MW-1:0] line12_rms,
    output logic      [svp_pkg::MW-1:0] line23_rms,
    output logic      [svp_pkg::MW-1:0] line31_rms,
    output logic                        upd
);
    import svp_pkg::*;
    int cnt_q;
    // refresh mid-period so the stage never samples a value in the act of changing
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= 0;
            upd <= 1'b0;
            pos_seq_rms <= '0;
            neg_seq_rms <= '0;
            line12_rms <= '0;
            line23_rms <= '0;
            line31_rms <= '0;
        end else begin
            cnt_q <= (cnt_q == TICK_CYCLES - 1) ? 0 : cnt_q + 1;
            upd <= (cnt_q == TICK_CYCLES / 2 - 1);
            if (cnt_q == TICK_CYCLES / 2 - 1) begin
                pos_seq_rms <= t_pos;
                neg_seq_rms <= t_neg;
                line12_rms <= t_line;
                line23_rms <= t_line + 16'h1;
                line31_rms <= t_line + 16'h2;
            end
        end
    end
endmodule
`default_nettype wire

// ---- tb/test_sequence_voltage_pickup.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_sequence_voltage_pickup;
    import svp_pkg::*;
    localparam int TK = 20;
    logic          clk       = 1'b0;
    logic          rstn      = 1'b0;
    logic [AW-1:0] addr      = '0;
    logic [DW-1:0] wdata     = '0;
    logic          wr        = 1'b0;
    logic          rd        = 1'b0;
    logic          block_in  = 1'b0;
    logic          force_en  = 1'b0;
    logic [GW-1:0] group_sel = '0;
    logic [MW-1:0] t_pos     = '0;
    logic [MW-1:0] t_neg     = '0;
    logic [MW-1:0] t_line    = '0;
    logic [MW-1:0] pos, neg, l12, l23, l31;
    logic [DW-1:0] rdata;
    logic          start, trip, blocked, upd;
    int            bad_count = 0;
    int            samples_checked = 0;
    // short tick keeps the run brief
    svp_stage #(.TICK_CYCLES(TK)) u_svp_stage (
        .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .pos_seq_rms(pos), .neg_seq_rms(neg), .line12_rms(l12), .line23_rms(l23),
        .line31_rms(l31), .block_in(block_in), .stage_force_en(force_en),
        .group_sel(group_sel), .start(start), .trip(trip), .blocked(blocked)
    );
    svp_meas_model #(.TICK_CYCLES(TK)) u_svp_meas_model (
        .clk(clk), .rstn(rstn), .t_pos(t_pos), .t_neg(t_neg), .t_line(t_line),
        .pos_seq_rms(pos), .neg_seq_rms(neg), .line12_rms(l12), .line23_rms(l23),
        .line31_rms(l31), .upd(upd)
    );
    initial begin
        forever #5 clk = ~clk;
    end
    ////////////////////////////////////////
    task automatic chk(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic so(input logic [2:0] e);
        chk({29'h0, start, trip, blocked}, {29'h0, e});
    endtask
    task automatic wreg(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rchk(input logic [AW-1:0] a, input logic [DW-1:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, e);
    endtask
    // wait for a model refresh, then for the stage tick that takes it
    task automatic tick(input int n);
        repeat (n) begin
            for (int i = 0; i < TK && !upd; i++) begin
                @(posedge clk);
                #1;
            end
            repeat (TK / 2 + 1) @(posedge clk);
            #1;
        end
    endtask
    ////////////////////////////////////////
    task automatic t_reset();
        rchk(OFS_CTRL, 32'h4);
        rchk(OFS_USET, 32'h2904);
        rchk(OFS_UNDER_BLOCK_LEVEL, 32'h1f4);
        rchk(OFS_EXPTIME, 32'h8);
        rchk(OFS_PRIMARY, 32'h41a);
        rchk(8'h3c, 32'h0);
    endtask
    task automatic t_over();
        wreg(OFS_OPDLY, 32'h2);
        t_pos = 16'h2968;
        tick(1);
        so(3'b100);
        rchk(OFS_RATIO, 32'h64);
        rchk(OFS_REMTIME, 32'h1);
        tick(1);
        rchk(OFS_REMTIME, 32'h0);
        tick(1);
        so(3'b110);
        t_pos = 16'h27c9;
        tick(1);
        so(3'b110);
        t_pos = 16'h27c8;
        tick(1);
        so(3'b000);
    endtask
    task automatic t_block();
        @(posedge clk) block_in <= 1'b1;
        t_pos = 16'h2968;
        tick(1);
        so(3'b001);
        rchk(OFS_STATUS, 32'h9);
        @(posedge clk) block_in <= 1'b0;
        tick(1);
        so(3'b100);
        @(posedge clk) block_in <= 1'b1;
        tick(1);
        so(3'b001);
        @(posedge clk) block_in <= 1'b0;
        t_pos = 16'h0;
        tick(1);
        so(3'b000);
    endtask
    task automatic t_force();
        logic [2:0] fx [4] = '{3'b000, 3'b100, 3'b110, 3'b001};
        @(posedge clk) force_en <= 1'b1;
        for (int f = 0; f < 4; f++) begin
            wreg(OFS_CTRL, 32'h4 | 32'(f));
            repeat (2) @(posedge clk);
            #1;
            so(fx[f]);
        end
        @(posedge clk) group_sel <= 3'h5;
        rchk(OFS_CTRL, 32'h7);
        @(posedge clk) force_en <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        so(3'b000);
        wreg(OFS_CTRL, 32'h4);
    endtask
    task automatic t_mag();
        wreg(OFS_CTRL, 32'h8);
        t_neg = 16'h1234;
        t_pos = 16'h0100;
        tick(1);
        rchk(OFS_CALC, 32'h1234);
        wreg(OFS_CTRL, 32'h4);
        tick(1);
        rchk(OFS_CALC, 32'h0100);
    endtask
    task automatic t_under();
        wreg(OFS_USET + 8'h4, 32'h1f40);
        @(posedge clk) group_sel <= 3'h1;
        wreg(OFS_OPDLY, 32'h0);
        t_line = 16'h2328;
        t_pos = 16'h1edc;
        tick(1);
        wreg(OFS_CTRL, 32'h14);
        tick(1);
        so(3'b110);
        rchk(OFS_PRIMARY, 32'h320);
        t_pos = 16'h2030;
        tick(1);
        so(3'b110);
        t_pos = 16'h2031;
        tick(1);
        so(3'b000);
        t_line = 16'h1b58;
        t_pos = 16'h01f3;
        tick(1);
        so(3'b100);
        rchk(OFS_STATUS, 32'h13);
        t_pos = 16'h1edc;
        tick(1);
        so(3'b100);
        t_line = 16'h1f41;
        tick(2);
        so(3'b110);
        wreg(OFS_UNDER_BLOCK_LEVEL, 32'h0);
        t_line = 16'h1b58;
        t_pos = 16'h0064;
        tick(1);
        so(3'b110);
    endtask
    // the sample four ticks back differs from older ones, so a window one tick off shows
    task automatic t_pre();
        wreg(OFS_CTRL, 32'h4);
        @(posedge clk) group_sel <= 3'h0;
        t_pos = 16'h2328;
        tick(8);
        t_pos = 16'h251c;
        tick(4);
        t_pos = 16'h2af8;
        tick(1);
        so(3'b110);
        // samples 4..7 ticks back: one at 9500, three at 9000
        rchk(OFS_PREFAULT, 32'h23a5);
    endtask
    ////////////////////////////////////////
    task automatic conclude();
        $display("compares %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        t_reset();
        t_over();
        t_block();
        t_force();
        t_mag();
        t_under();
        t_pre();
        @(posedge clk) rstn <= 1'b0;
        @(posedge clk);
        #1;
        so(3'b000);
        conclude();
    end
    // about forty ticks of traffic; five times that is a hang
    initial begin
        repeat (4000) @(posedge clk);
        bad_count++;
        conclude();
    end
endmodule
bind svp_stage svp_stage_sva #(.TICK_CYCLES(TICK_CYCLES)) u_svp_stage_sva (
    .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .block_in(block_in),
    .stage_force_en(stage_force_en), .start(start), .trip(trip), .blocked(blocked)
);
`default_nettype wire
